/* File: core/scclsq_pkg.sv */
// How it works
// - A valid start opens a six-edge cycle loading six words into six latches.
// - Start must be high on the active edge before the first word is taken.
// - Edge-select high loads on clock rise, low on clock fall; start likewise.
// - Direction high fills channel 0 upward; low fills channel 5 downward.
// - Transfer high at a clock rise copies all latches out at next fall.
// - Invert high: level is upper minus code span; low: lower plus span.
// - Power-down clears all stored words and sequence state until released.
// - Codes run 0 to 1023; invert picks which side of midpoint is driven.
package scclsq_pkg;

    // =========================================================
    // Geometry
    localparam int NUM_CH = 6;
    localparam int WORD_W = 10;
    localparam logic [WORD_W-1:0] CODE_MAX = 10'h3ff;

    // =========================================================
    // Register map (byte addresses)
    localparam logic [5:0] CTRL_OFS = 6'h00;
    localparam logic [5:0] STATUS_OFS = 6'h04;
    localparam logic [5:0] CODE_BASE_OFS = 6'h20;

    // Control register fields
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_INV_BIT = 2;
    localparam int CTRL_PD_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    // Status register fields
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_LOADING_BIT = 4;
    localparam int STAT_ARMED_BIT = 5;
    localparam int STAT_XFER_BIT = 6;

    // =========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_LOAD = 2'b10
    } scclsq_state_t;

endpackage

/* File: core/scclsq_channel.sv */
`timescale 1ns/1ps

// =============================================================
// One channel: input latch, output latch, level computation
module scclsq_channel
    import scclsq_pkg::*;
#(
    parameter int WIDTH = WORD_W
) (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic clear, // Power-down wipe
    input wire logic load_en, // Capture input word
    input wire logic [WIDTH-1:0] word_in, // Input word
    input wire logic xfer_en, // Copy latch to output
    input wire logic invert, // Polarity select
    output logic [WIDTH-1:0] latch_q, // Loaded word
    output logic [WIDTH-1:0] code_q, // Transferred word
    output logic signed [WIDTH:0] level_q // Level around midpoint
);

    logic [WIDTH-1:0] latch_reg, latch_next;
    logic [WIDTH-1:0] code_reg, code_next;
    logic signed [WIDTH:0] level_reg, level_next;
    logic signed [WIDTH:0] span;
    localparam logic [WIDTH-1:0] TOP_CODE = '1; // Highest code at this width

    // Next values of both stages and the level
    always_comb begin
        latch_next = latch_reg;
        code_next = code_reg;
        span = $signed({1'b0, TOP_CODE - code_reg});
        level_next = invert ? span : -span;
        if (clear) begin
            latch_next = '0;
            code_next = '0;
        end else begin
            if (load_en)
                latch_next = word_in;
            if (xfer_en)
                code_next = latch_reg;
        end
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latch_reg <= '0;
            code_reg <= '0;
            level_reg <= '0;
        end else begin
            latch_reg <= latch_next;
            code_reg <= code_next;
            level_reg <= level_next;
        end
    end

    assign latch_q = latch_reg;
    assign code_q = code_reg;
    assign level_q = level_reg;

    // =========================================================
    // Checks
    a_xfer_copies: assert property (@(posedge sys_clk) disable iff (sys_rst)
        xfer_en && !clear |=> code_reg == $past(latch_reg))
        else $error("transfer did not copy latch");
    a_level_inv: assert property (@(posedge sys_clk) disable iff (sys_rst)
        invert |=> level_reg ==
            $signed({1'b0, TOP_CODE - $past(code_reg)}))
        else $error("inverted level wrong");
    a_level_sign: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !invert ##1 !invert |-> level_reg <= 0)
        else $error("non-inverted level above midpoint");
    a_hold_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !xfer_en && !clear |=> $stable(code_reg))
        else $error("output changed without transfer");

endmodule // scclsq_channel

/* File: core/scclsq_top.sv */
`timescale 1ns/1ps

// =============================================================
// Six-channel column load sequencer with Avalon-MM control
module scclsq_top
    import scclsq_pkg::*;
#(
    parameter int CH = NUM_CH,
    parameter int WIDTH = WORD_W
) (
    input wire logic sys_clk, // System clock, 125 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic pixel_clk, // Load clock, sampled
    input wire logic [WIDTH-1:0] pixel_word_in, // Data word, MSB top
    input wire logic sequence_start, // Start of six-word load
    input wire logic output_transfer, // Move latches to outputs
    input wire logic [5:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic [CH-1:0][WIDTH-1:0] column_output, // Transferred codes
    output logic [CH-1:0][WIDTH:0] column_level // Signed level offsets
);

    localparam int IDX_W = $clog2(CH);
    localparam int CNT_W = $clog2(CH + 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(CH);

    // Refuse sizes the index, status and readback fields cannot hold
    if (CH < 2 || CH > 8 || WIDTH < 2 || WIDTH > 16) begin : g_bad_size
        $error("scclsq_top: unsupported CH or WIDTH");
    end

    // =========================================================
    // Register bus
    logic [3:0] ctrl_reg, ctrl_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic edge_sel, load_dir, invert, pd;
    logic [CH-1:0][WIDTH-1:0] latch_w;
    logic [5:0] code_ofs;

    // Sequencer state
    scclsq_state_t state_reg, state_next;
    logic pclk_prev_reg, pclk_prev_next;
    logic armed_reg, armed_next;
    logic xfer_pend_reg, xfer_pend_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic rise, fall, act, load_en, xfer_en;
    logic [IDX_W-1:0] load_idx;

    assign edge_sel = ctrl_reg[CTRL_EDGE_BIT];
    assign load_dir = ctrl_reg[CTRL_DIR_BIT];
    assign invert = ctrl_reg[CTRL_INV_BIT];
    assign pd = ctrl_reg[CTRL_PD_BIT];

    // One-cycle stall, then answer; read data captured in stall
    always_comb begin
        ack_next = (avs_read | avs_write) & ~ack_reg;
        ctrl_next = ctrl_reg;
        rdata_next = rdata_reg;
        code_ofs = avs_address - CODE_BASE_OFS;
        if (avs_write && ack_reg && avs_address == CTRL_OFS
            && avs_byteenable[0])
            ctrl_next = avs_writedata[3:0];
        if (avs_read && !ack_reg) begin
            rdata_next = 32'h0;
            if (avs_address == CTRL_OFS) begin
                rdata_next[3:0] = ctrl_reg;
            end else if (avs_address == STATUS_OFS) begin
                rdata_next[STAT_CNT_LSB +: CNT_W] = cnt_reg;
                rdata_next[STAT_LOADING_BIT] = state_reg == SEQ_LOAD;
                rdata_next[STAT_ARMED_BIT] = armed_reg;
                rdata_next[STAT_XFER_BIT] = xfer_pend_reg;
            end else if (avs_address >= CODE_BASE_OFS
                && code_ofs[1:0] == 2'h0 && code_ofs[5:2] < 4'(CH)) begin
                rdata_next[WIDTH-1:0] = column_output[code_ofs[5:2]];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg <= ack_next;
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdata_reg;

    // =========================================================
    // Edge detection on the sampled load clock
    assign rise = pixel_clk & ~pclk_prev_reg;
    assign fall = ~pixel_clk & pclk_prev_reg;
    assign act = (edge_sel ? rise : fall) & ~pd;

    // Load sequencer and transfer request
    always_comb begin
        pclk_prev_next = pixel_clk;
        state_next = state_reg;
        armed_next = armed_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        xfer_pend_next = xfer_pend_reg;
        load_en = 1'b0;
        load_idx = idx_reg;
        xfer_en = fall & xfer_pend_reg & ~pd;
        if (pd) begin
            state_next = SEQ_IDLE;
            armed_next = 1'b0;
            cnt_next = '0;
            xfer_pend_next = 1'b0;
        end else begin
            if (rise)
                xfer_pend_next = output_transfer;
            else if (fall)
                xfer_pend_next = 1'b0;
            if (act) begin
                armed_next = sequence_start;
                case (state_reg)
                    SEQ_IDLE, SEQ_LOAD: begin
                        if (armed_reg) begin
                            load_en = 1'b1;
                            load_idx = load_dir ? '0 : LAST_IDX;
                            idx_next = load_dir ? IDX_W'(1)
                                : LAST_IDX - IDX_W'(1);
                            cnt_next = CNT_W'(1);
                            state_next = SEQ_LOAD;
                        end else if (state_reg == SEQ_LOAD) begin
                            load_en = 1'b1;
                            idx_next = load_dir ? idx_reg + IDX_W'(1)
                                : idx_reg - IDX_W'(1);
                            cnt_next = cnt_reg + CNT_W'(1);
                            if (cnt_reg + CNT_W'(1) == FULL_CNT)
                                state_next = SEQ_IDLE;
                        end
                    end
                    default: state_next = SEQ_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= SEQ_IDLE;
            pclk_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            xfer_pend_reg <= 1'b0;
            idx_reg <= '0;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            pclk_prev_reg <= pclk_prev_next;
            armed_reg <= armed_next;
            xfer_pend_reg <= xfer_pend_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
        end
    end

    // =========================================================
    // Channel latches
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            scclsq_channel #(.WIDTH(WIDTH)) u_ch (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .clear(pd),
                .load_en(load_en && load_idx == IDX_W'(g)),
                .word_in(pixel_word_in),
                .xfer_en(xfer_en),
                .invert(invert),
                .latch_q(latch_w[g]),
                .code_q(column_output[g]),
                .level_q(column_level[g])
            );
        end
    endgenerate

    // =========================================================
    // Checks
    a_start_opens: assert property (@(posedge sys_clk) disable iff (sys_rst)
        act && armed_reg |=> state_reg == SEQ_LOAD && cnt_reg == 1)
        else $error("start did not open a load cycle");
    a_prior_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
        act |=> armed_reg == $past(sequence_start))
        else $error("start not sampled on active edge");
    a_edge_choice: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_en |-> (edge_sel ? (pixel_clk && !pclk_prev_reg)
            : (!pixel_clk && pclk_prev_reg)))
        else $error("word loaded on wrong edge");
    a_first_chan: assert property (@(posedge sys_clk) disable iff (sys_rst)
        act && armed_reg && load_dir ##1 state_reg == SEQ_LOAD
            |-> latch_w[0] == $past(pixel_word_in))
        else $error("upward load did not start at channel 0");
    a_pd_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pd |=> cnt_reg == 0 && !armed_reg && latch_w[0] == 0
            && column_output[0] == 0)
        else $error("power-down kept stored data");
    a_six_words: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cnt_reg == FULL_CNT |-> state_reg == SEQ_IDLE)
        else $error("loading ran past the last word");

endmodule // scclsq_top

/* File: bench/scclsq_partner.sv */
`timescale 1ns/1ps

// =============================================================
// Image processor model: load clock, words, start and transfer
module scclsq_partner
    import scclsq_pkg::*;
(
    input wire logic sys_clk, // System clock
    output logic pixel_clk = 1'b0, // Load clock, still between frames
    output logic [WORD_W-1:0] pixel_word_in = '0, // Word, bit 9 MSB
    output logic sequence_start = 1'b0, // Start of a load
    output logic output_transfer = 1'b0 // Move latches to outputs
);
    // One half period of three system cycles
    task automatic half(input logic lvl, input logic st,
                        input logic [WORD_W-1:0] wd, input logic xf);
        pixel_clk <= lvl;
        sequence_start <= st;
        pixel_word_in <= wd;
        output_transfer <= xf;
        repeat (3) @(posedge sys_clk);
    endtask

    // Start period, nw words, then an optional transfer
    task automatic frame(input logic [WORD_W-1:0] w [7], input int nw,
                         input logic st, input logic xf, input logic rise);
        logic [WORD_W-1:0] idle;
        idle = ~pixel_word_in;
        half(!rise, st, idle, 1'b0);
        half(rise, st, ~idle, 1'b0);
        for (int i = 0; i < nw; i++) begin
            half(!rise, 1'b0, w[i], 1'b0);
            half(rise, 1'b0, w[i], 1'b0);
        end
        // Transfer held over a clean rise and the fall after it
        if (xf) begin
            half(!rise, 1'b0, ~w[0], 1'b1);
            half(rise, 1'b0, w[0], 1'b1);
            half(!rise, 1'b0, ~w[0], 1'b1);
            half(rise, 1'b0, w[0], 1'b0);
        end
        // Released data lines show the inverse, not the last word
        pixel_word_in <= ~pixel_word_in;
        @(posedge sys_clk);
    endtask
endmodule // scclsq_partner

/* File: bench/tb_top.sv */
`timescale 1ns/1ps

// =============================================================
// Testbench for the column load sequencer
module tb_top
    import scclsq_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pixel_clk, sequence_start, output_transfer;
    logic [WORD_W-1:0] pixel_word_in;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest;
    logic [NUM_CH-1:0][WORD_W-1:0] column_output;
    logic [NUM_CH-1:0][WORD_W:0] column_level;
    logic [WORD_W-1:0] exp_code [NUM_CH];
    logic [WORD_W-1:0] w [7];
    logic e, dir, polarity_invert;
    int n_fail = 0;
    int cmp_count = 0;

    // =========================================================
    // Clock, design and far side
    always #4 sys_clk = ~sys_clk;

    scclsq_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pixel_clk(pixel_clk), .pixel_word_in(pixel_word_in),
        .sequence_start(sequence_start),
        .output_transfer(output_transfer), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .column_output(column_output), .column_level(column_level));

    scclsq_partner i_partner (.sys_clk(sys_clk), .pixel_clk(pixel_clk),
        .pixel_word_in(pixel_word_in), .sequence_start(sequence_start),
        .output_transfer(output_transfer));

    // =========================================================
    // Reporting
    task automatic check(input logic [31:0] got, input logic [31:0] want,
                         input string what);
        cmp_count++;
        if (got !== want) begin
            n_fail++;
            $display("Error at %0t: %s got %h want %h", $time, what, got,
                     want);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // =========================================================
    // Avalon master: hold until waitrequest is seen low
    task automatic av(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) check(32'h1, 32'h0, "bus timeout");
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Control word from edge, direction, invert, power-down
    task automatic set_mode(input logic pd);
        logic [31:0] d;
        d = '0;
        d[CTRL_EDGE_BIT] = e;
        d[CTRL_DIR_BIT] = dir;
        d[CTRL_INV_BIT] = polarity_invert;
        d[CTRL_PD_BIT] = pd;
        av(1'b1, CTRL_OFS, d);
    endtask

    // Outputs, levels and read-back against expected codes
    task automatic check_out();
        logic [WORD_W:0] t;
        repeat (4) @(posedge sys_clk);
        for (int k = 0; k < NUM_CH; k++) begin
            t = {1'b0, CODE_MAX - exp_code[k]};
            if (!polarity_invert) t = ~t + 11'h1;
            check({22'h0, column_output[k]},
                  {22'h0, exp_code[k]}, "code");
            check({21'h0, column_level[k]}, {21'h0, t}, "level");
            av(1'b0, CODE_BASE_OFS + 6'(4 * k), 32'h0);
            check(rd, {22'h0, exp_code[k]}, "readback");
        end
    endtask

    // =========================================================
    // Test sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        av(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h1, "control reset");
        av(1'b0, 6'h10, 32'h0);
        check(rd, 32'h0, "unmapped read");
        // Control write with lane 0 masked must leave control alone
        avs_byteenable <= 4'he;
        av(1'b1, CTRL_OFS, 32'h0);
        avs_byteenable <= 4'hf;
        av(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h1, "masked write");
        polarity_invert = 1'b0;
        foreach (exp_code[k]) exp_code[k] = '0;
        check_out();
        $display("Test reset done");
        // Every edge and direction; seventh word must be dropped
        for (int m = 0; m < 4; m++) begin
            e = m[0];
            dir = m[1];
            polarity_invert = m[0] ^ m[1];
            set_mode(1'b0);
            foreach (w[i]) w[i] = (i == 0) ? 10'h000 : (i == 5) ? CODE_MAX
                                  : 10'(m * 96 + i * 37);
            for (int i = 0; i < 6; i++) exp_code[dir ? i : 5 - i] = w[i];
            i_partner.frame(w, 7, 1'b1, 1'b1, e);
            check_out();
            $display("Test mode %0d done", m);
        end
        // Load without transfer holds outputs; no start ignores words
        foreach (w[i]) w[i] = 10'h155 + 10'(i);
        i_partner.frame(w, 6, 1'b1, 1'b0, e);
        check_out();
        av(1'b0, STATUS_OFS, 32'h0);
        check(rd, 32'(NUM_CH) << STAT_CNT_LSB, "status full");
        for (int i = 0; i < 6; i++) exp_code[i] = w[i];
        foreach (w[i]) w[i] = 10'h2aa - 10'(i);
        i_partner.frame(w, 6, 1'b0, 1'b1, e);
        check_out();
        $display("Test hold done");
        // Power-down wipes everything and blocks loading
        set_mode(1'b1);
        foreach (exp_code[k]) exp_code[k] = '0;
        check_out();
        i_partner.frame(w, 6, 1'b1, 1'b1, e);
        check_out();
        av(1'b0, STATUS_OFS, 32'h0);
        check(rd, 32'h0, "status cleared");
        set_mode(1'b0);
        i_partner.frame(w, 0, 1'b0, 1'b1, e);
        check_out();
        $display("Test power-down done");
        finish_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // tb_top
